// ===== rcbio_top.sv
// Purpose: control-board glue logic around the radio controller ports
// Assumes: all inputs synchronous to ref_clk, synchronous active-low reset
// Notes:   analog routes are modelled as select lines for switches
// Behaviour
// - variant select output low for first secure variant, high for second.
// - variant select held low while a key fill frame is active.
// - outgoing zeroise line follows the active-low mode switch erase input.
// - controller zeroise command also pulls the zeroise line low.
// - volume code bits are the inverted volume switch lines.
// - volume code is 3-bit binary, bit 0 from first line, 0 quietest.
// - whisper high when both upper switch lines are high.
// - squelch override high when both upper switch lines are low.
// - fixed-level audio request forces volume code to 4.
// - exactly one of eight volume outputs selected, indexed by the code.
// - receive audio passes only while filter control is low.
// - tone level select high picks the high-level tone path, else low.
// - amplifier input is volume audio, or wideband audio when selected.
// - amplifier powered only while its power control is high.
// - squelch path carries received signal unless transmitting, then tone.
// - tone-squelch input held low while reset or irq gate enable low.
// - two modulation gain bits select one of four buffer gains.
// - crypto clock generator power driven high permanently.
// - active-low clear-to-send output driven from its latch bit.
// - pwm reply appears inverted at the push-to-talk pin.
// - one serial clock shared by synthesiser, fill and init register read.
// - reference divisor data also enables the init register data output.
// - each latch bank captures port data on its strobe rising edge.
// - mode bits decode 00 sec b, 01 clear, 10 sec a, 11 zeroise.
module rcbio_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // controller latch port
  input  wire logic [7:0]  port_b_data,
  input  wire logic        latch_strobe_a,
  input  wire logic        latch_strobe_b,
  // controller direct outputs
  input  wire logic        zeroise_command,
  input  wire logic        fill_frame,
  input  wire logic        tone_level_select,
  input  wire logic        irq_gate_enable,
  input  wire logic        pwm_reply_out,
  input  wire logic        serial_clock,
  input  wire logic        synth_ref_divisor_data,
  input  wire logic        synth_var_divisor_data,
  input  wire logic        synth_frame,
  input  wire logic        squelch_tone_out,
  input  wire logic        warning_tone_out,
  input  wire logic        wideband_select,
  // switches and partner boards
  input  wire logic        mode_switch_erase,
  input  wire logic [1:0]  mode_select,
  input  wire logic [2:0]  vol_switch,
  input  wire logic        fixed_level_audio_req,
  input  wire logic        received_signal,
  input  wire logic        slicer_in,
  // controller inputs
  output logic             squelch_override,
  output logic             tone_squelch_in,
  output logic [1:0]       mode_decoded,
  // crypto board
  output logic             zeroise_line_out,
  output logic             whisper_out,
  output logic             cipher_variant_select,
  output logic             cipher_variant_select_hi,
  output logic             secure_select_n,
  output logic             crypto_tx_control,
  output logic             crypto_clockgen_power,
  output logic             tfilter_power,
  output logic             fill_clock,
  // transceiver board
  output logic             transmit_control_n,
  output logic             synth_clock,
  output logic             synth_ref_out,
  output logic             synth_var_out,
  output logic             synth_frame_out,
  output logic             init_data_oe,
  output logic             squelch_path,
  output logic             mod_gain_sel_a,
  output logic             mod_gain_sel_b,
  // audio path selects
  output logic             audio_filter_power_n,
  output logic             rx_audio_pass,
  output logic             tone_level_pin,
  output logic             tone_path_high,
  output logic             tone_path_low,
  output logic [2:0]       vol_code,
  output logic [7:0]       vol_mux_sel,
  output logic             amp_from_wideband,
  output logic             audio_amp_power,
  // front panel and misc
  output logic             clear_to_send_n,
  output logic             tx_lamp_n,
  output logic             ptt_pull_low,
  output logic             tsq_filter_power,
  output logic             eeprom_power
);
  rcbio_latch_if #(.W(rcbio_pkg::BANK_W)) lat_a ();
  rcbio_latch_if #(.W(rcbio_pkg::BANK_W)) lat_b ();

  assign lat_a.strobe = latch_strobe_a;
  assign lat_a.data   = port_b_data;
  assign lat_b.strobe = latch_strobe_b;
  assign lat_b.data   = port_b_data;

  rcbio_latch_bank #(
    .W   (rcbio_pkg::BANK_W),
    .RST (rcbio_pkg::BANK_A_RST)
  ) u_bank_a (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .lif     (lat_a)
  );

  rcbio_latch_bank #(
    .W   (rcbio_pkg::BANK_W),
    .RST (rcbio_pkg::BANK_B_RST)
  ) u_bank_b (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .lif     (lat_b)
  );

  logic [7:0] a_q;
  logic [7:0] b_q;
  assign a_q = lat_a.q;
  assign b_q = lat_b.q;

  // latched control outputs
  logic       variant_d;
  logic       variant_q;
  logic       zer_q;
  logic [2:0] vol_d;
  logic [2:0] vol_q;
  logic       whisper_q;
  logic       override_q;
  logic       tsq_q;
  logic       squelch_q;
  logic       reply_q;
  logic [1:0] mode_q;

  // variant select, forced low during fill
  always_comb begin
    variant_d = a_q[rcbio_pkg::A_VARIANT];
    if (fill_frame) begin
      variant_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      variant_q <= 1'b0;
    end else begin
      variant_q <= variant_d;
    end
  end

  assign cipher_variant_select    = variant_q;
  assign cipher_variant_select_hi = a_q[rcbio_pkg::A_VARIANT_HI];
  assign secure_select_n          = a_q[rcbio_pkg::A_SEC_N];
  assign crypto_tx_control        = a_q[rcbio_pkg::A_CRYPTO_TX];
  assign audio_filter_power_n     = a_q[rcbio_pkg::A_FILTER_N];
  assign transmit_control_n       = a_q[rcbio_pkg::A_TX_CTRL_N];
  assign tx_lamp_n                = a_q[rcbio_pkg::A_TX_LAMP_N];
  assign mod_gain_sel_a           = a_q[rcbio_pkg::A_MOD_GAIN];
  assign mod_gain_sel_b           = b_q[rcbio_pkg::B_MOD_GAIN];
  assign audio_amp_power          = b_q[rcbio_pkg::B_AMP_PWR];
  assign clear_to_send_n          = b_q[rcbio_pkg::B_CTS_N];
  assign tsq_filter_power         = b_q[rcbio_pkg::B_TSQ_PWR];
  assign tfilter_power            = b_q[rcbio_pkg::B_TFILT_PWR];
  assign eeprom_power             = b_q[rcbio_pkg::B_EEPROM_PWR];

  // clock generator power forced high
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      crypto_clockgen_power <= 1'b1;
    end else begin
      crypto_clockgen_power <= 1'b1;
    end
  end

  // zeroise line: low on switch erase or controller command
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      zer_q <= 1'b1;
    end else begin
      zer_q <= mode_switch_erase & ~zeroise_command;
    end
  end
  assign zeroise_line_out = zer_q;

  // volume code: inverted switch lines, fixed level override
  always_comb begin
    vol_d = ~vol_switch;
    if (fixed_level_audio_req) begin
      vol_d = rcbio_pkg::VOL_FIXED;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      vol_q      <= 3'h0;
      whisper_q  <= 1'b0;
      override_q <= 1'b0;
    end else begin
      vol_q      <= vol_d;
      whisper_q  <= vol_switch[2] & vol_switch[1];
      override_q <= ~vol_switch[2] & ~vol_switch[1];
    end
  end
  assign vol_code         = vol_q;
  assign whisper_out      = whisper_q;
  assign squelch_override = override_q;

  // one-hot multiplexer select
  genvar gi;
  generate
    for (gi = 0; gi < rcbio_pkg::VOL_OUTS; gi++) begin : g_vmux
      assign vol_mux_sel[gi] = (vol_q == 3'(gi));
    end
  endgenerate

  // audio routing selects
  assign rx_audio_pass     = ~a_q[rcbio_pkg::A_FILTER_N];
  assign tone_level_pin    = tone_level_select;
  assign tone_path_high    = warning_tone_out & tone_level_select;
  assign tone_path_low     = warning_tone_out & ~tone_level_select;
  assign amp_from_wideband = wideband_select;

  // squelch path and tone-squelch gate
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      squelch_q <= 1'b0;
      tsq_q     <= 1'b0;
    end else begin
      squelch_q <= a_q[rcbio_pkg::A_TX_CTRL_N] ? received_signal
                                                : squelch_tone_out;
      tsq_q     <= slicer_in & irq_gate_enable;
    end
  end
  assign squelch_path    = squelch_q;
  assign tone_squelch_in = tsq_q;

  // reply inverted onto push-to-talk line: high reply pulls it low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reply_q <= 1'b0;
    end else begin
      reply_q <= pwm_reply_out;
    end
  end
  assign ptt_pull_low = reply_q;

  // shared serial clock and synthesiser lines
  assign synth_clock     = serial_clock;
  assign fill_clock      = serial_clock;
  assign synth_ref_out   = synth_ref_divisor_data;
  assign init_data_oe    = synth_ref_divisor_data;
  assign synth_var_out   = synth_var_divisor_data;
  assign synth_frame_out = synth_frame;

  // mode decode: 0 sec b, 1 clear, 2 sec a, 3 zeroise
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      mode_q <= rcbio_pkg::MODE_CLEAR;
    end else begin
      case ({mode_select[0], mode_select[1]})
        2'h0:    mode_q <= rcbio_pkg::MODE_SEC_B;
        2'h2:    mode_q <= rcbio_pkg::MODE_CLEAR;
        2'h1:    mode_q <= rcbio_pkg::MODE_SEC_A;
        default: mode_q <= rcbio_pkg::MODE_ZEROISE;
      endcase
    end
  end
  assign mode_decoded = mode_q;

  a_variant_fill: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fill_frame |=> !cipher_variant_select)
    else $error("variant select high during fill");

  a_variant_follow: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fill_frame |=> cipher_variant_select == $past(a_q[2]))
    else $error("variant select does not follow latch");

  a_zeroise_line: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zeroise_command || !mode_switch_erase) |=> !zeroise_line_out)
    else $error("zeroise line not driven low");

  a_vol_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !fixed_level_audio_req |=> vol_code == ~$past(vol_switch))
    else $error("volume code not inverted switch");

  a_vol_fixed: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fixed_level_audio_req |=> vol_code == 3'h4)
    else $error("fixed level audio not applied");

  a_whisper_det: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (vol_switch[2] && vol_switch[1]) |=> whisper_out && !squelch_override)
    else $error("whisper not asserted");

  a_override_det: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!vol_switch[2] && !vol_switch[1]) |=> squelch_override && !whisper_out)
    else $error("squelch override not asserted");

  a_vmux_onehot: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $onehot(vol_mux_sel) && vol_mux_sel[vol_code])
    else $error("volume select not one-hot on code");

  a_tsq_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !irq_gate_enable |=> !tone_squelch_in)
    else $error("tone squelch not gated");

  a_squelch_tx: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !a_q[5] |=> squelch_path == $past(squelch_tone_out))
    else $error("squelch path not on tone in transmit");

  a_clkgen_high: assert property (@(posedge ref_clk) disable iff (!reset_n)
    crypto_clockgen_power)
    else $error("clock generator power dropped");

  a_reply_inv: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pwm_reply_out |=> ptt_pull_low)
    else $error("reply not driven onto ptt line");

  a_zeroise_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!zeroise_command && mode_switch_erase) |=> zeroise_line_out)
    else $error("zeroise line low without a request");

  a_squelch_rx: assert property (@(posedge ref_clk) disable iff (!reset_n)
    a_q[rcbio_pkg::A_TX_CTRL_N] |=> squelch_path == $past(received_signal))
    else $error("squelch path not on received signal");

  a_tsq_pass: assert property (@(posedge ref_clk) disable iff (!reset_n)
    irq_gate_enable |=> tone_squelch_in == $past(slicer_in))
    else $error("tone squelch not passed while enabled");

  a_mode_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode_select == 2'h1) |=> mode_decoded == rcbio_pkg::MODE_CLEAR)
    else $error("clear mode pattern not decoded");

  a_tone_route: assert property (@(posedge ref_clk) disable iff (!reset_n)
    warning_tone_out |-> tone_path_high == tone_level_select)
    else $error("warning tone on wrong level path");
endmodule : rcbio_top

// ===== rcbio_pkg.sv
// Purpose: shared constants for the control-board glue logic
// Assumes: one clock, synchronous active-low reset
// Notes:   reset levels are the inactive levels of each latched output
package rcbio_pkg;
  // latch bank widths and bit positions (bank a)
  localparam int          BANK_W          = 8;
  localparam int          A_SEC_N         = 0;
  localparam int          A_CRYPTO_TX     = 1;
  localparam int          A_VARIANT       = 2;
  localparam int          A_VARIANT_HI    = 3;
  localparam int          A_FILTER_N      = 4;
  localparam int          A_TX_CTRL_N     = 5;
  localparam int          A_TX_LAMP_N     = 6;
  localparam int          A_MOD_GAIN      = 7;
  // bank b
  localparam int          B_CLKGEN_PWR    = 1;
  localparam int          B_AMP_PWR       = 2;
  localparam int          B_CTS_N         = 3;
  localparam int          B_TSQ_PWR       = 4;
  localparam int          B_TFILT_PWR     = 5;
  localparam int          B_EEPROM_PWR    = 6;
  localparam int          B_MOD_GAIN      = 7;
  // reset values: active-low lines idle high, active-high idle low
  localparam logic [7:0]  BANK_A_RST      = 8'h71;
  localparam logic [7:0]  BANK_B_RST      = 8'h08;
  // mode select encodings {mob, moa}
  localparam logic [1:0]  MODE_SEC_B      = 2'h0;
  localparam logic [1:0]  MODE_CLEAR      = 2'h1;
  localparam logic [1:0]  MODE_SEC_A      = 2'h2;
  localparam logic [1:0]  MODE_ZEROISE    = 2'h3;
  // fixed-level audio volume code
  localparam logic [2:0]  VOL_FIXED       = 3'h4;
  localparam int          VOL_W           = 3;
  localparam int          VOL_OUTS        = 8;
endpackage : rcbio_pkg

// ===== rcbio_latch_if.sv
// Purpose: carrier between the latch bank and the top level
// Assumes: one clock domain
// Notes:   strobe is the raw latch strobe level from the controller
interface rcbio_latch_if #(parameter int W = 8);
  logic         strobe;
  logic [W-1:0] data;
  logic [W-1:0] q;
  modport bank (input strobe, input data, output q);
  modport ctrl (output strobe, output data, input q);
endinterface : rcbio_latch_if

// ===== rcbio_latch_bank.sv
// Purpose: one output latch bank, captures on strobe rising edge
// Assumes: strobe synchronous to ref_clk
// Notes:   holds inactive levels until the first strobe after reset
module rcbio_latch_bank #(
  parameter int               W   = 8,
  parameter logic [W-1:0]     RST = '0
) (
  // clock and reset
  input  wire logic           ref_clk,
  input  wire logic           reset_n,
  // carrier
  rcbio_latch_if.bank         lif
);
  logic         strobe_q;
  logic [W-1:0] q_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= lif.strobe;
    end
  end

  // capture on rising edge only
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      q_q <= RST;
    end else if (lif.strobe && !strobe_q) begin
      q_q <= lif.data;
    end
  end

  assign lif.q = q_q;

  a_latch_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(lif.strobe && !strobe_q) |=> q_q == $past(q_q))
    else $error("latch changed without a strobe edge");

  a_latch_takes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (lif.strobe && !strobe_q) |=> q_q == $past(lif.data))
    else $error("latch missed data on strobe edge");
endmodule : rcbio_latch_bank

// ===== rcbio_panel_model.sv
// Purpose: model of switches, crypto board and transceiver lines
// Assumes: bench requests settle between clock edges
// Notes:   volume switch lines are the inverted code asked for
module rcbio_panel_model (
  // clock
  input  wire logic       ref_clk,
  // requests from the bench
  input  wire logic [2:0] req_vol,
  input  wire logic [1:0] req_mode,
  input  wire logic       req_erase_n,
  input  wire logic       req_fla,
  input  wire logic       req_rx,
  input  wire logic       req_slicer,
  // lines into the block
  output logic [2:0]      vol_switch = 3'h7,
  output logic [1:0]      mode_select = 2'h1,
  output logic            mode_switch_erase = 1'b1,
  output logic            fixed_level_audio_req = 1'b0,
  output logic            received_signal = 1'b0,
  output logic            slicer_in = 1'b0
);
  // contacts and board lines move only at a clock edge
  always @(posedge ref_clk) begin
    vol_switch            <= ~req_vol;
    mode_select           <= req_mode;
    mode_switch_erase     <= req_erase_n;
    fixed_level_audio_req <= req_fla;
    received_signal       <= req_rx;
    slicer_in             <= req_slicer;
  end
endmodule // rcbio_panel_model

// ===== test_radio_control_board_io_logic.sv
// Purpose: self-checking bench for the control-board glue logic
// Assumes: inputs change one ns after the rising clock edge
// Notes:   switch and board lines come from the panel model
module test_radio_control_board_io_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset_n = 1'b0, latch_strobe_a = 1'b0, latch_strobe_b = 1'b0;
  logic [7:0] port_b_data = 8'h00;
  logic zeroise_command = 1'b0, fill_frame = 1'b0, tone_level_select = 1'b0;
  logic irq_gate_enable = 1'b0, pwm_reply_out = 1'b0, serial_clock = 1'b0;
  logic synth_ref_divisor_data = 1'b0, synth_var_divisor_data = 1'b0, synth_frame = 1'b0;
  logic squelch_tone_out = 1'b0, warning_tone_out = 1'b0, wideband_select = 1'b0;
  logic [2:0] req_vol = 3'h0;
  logic [1:0] req_mode = 2'h1;
  logic req_erase_n = 1'b1, req_fla = 1'b0, req_rx = 1'b0, req_slicer = 1'b0;
  logic mode_switch_erase, fixed_level_audio_req, received_signal, slicer_in;
  logic [1:0] mode_select, mode_decoded;
  logic [2:0] vol_switch, vol_code;
  logic [7:0] vol_mux_sel, bank_a_v, bank_b_v;
  logic squelch_override, tone_squelch_in, zeroise_line_out, whisper_out;
  logic cipher_variant_select, cipher_variant_select_hi, secure_select_n, crypto_tx_control;
  logic crypto_clockgen_power, tfilter_power, fill_clock, transmit_control_n, synth_clock;
  logic synth_ref_out, synth_var_out, synth_frame_out, init_data_oe, squelch_path;
  logic mod_gain_sel_a, mod_gain_sel_b, audio_filter_power_n, rx_audio_pass, tone_level_pin;
  logic tone_path_high, tone_path_low, amp_from_wideband, audio_amp_power, clear_to_send_n;
  logic tx_lamp_n, ptt_pull_low, tsq_filter_power, eeprom_power;
  int num_errors = 0;
  int n_checks = 0;

  assign bank_a_v = {mod_gain_sel_a, tx_lamp_n, transmit_control_n, audio_filter_power_n,
                     cipher_variant_select_hi, cipher_variant_select, crypto_tx_control,
                     secure_select_n};
  assign bank_b_v = {mod_gain_sel_b, eeprom_power, tfilter_power, tsq_filter_power,
                     clear_to_send_n, audio_amp_power, crypto_clockgen_power, 1'b0};

  always #20 ref_clk = ~ref_clk;

  rcbio_panel_model panel_u (.ref_clk, .req_vol, .req_mode, .req_erase_n, .req_fla, .req_rx,
    .req_slicer, .vol_switch, .mode_select, .mode_switch_erase, .fixed_level_audio_req,
    .received_signal, .slicer_in);

  rcbio_top dut_u (.ref_clk, .reset_n, .port_b_data, .latch_strobe_a, .latch_strobe_b,
    .zeroise_command, .fill_frame, .tone_level_select, .irq_gate_enable, .pwm_reply_out,
    .serial_clock, .synth_ref_divisor_data, .synth_var_divisor_data, .synth_frame,
    .squelch_tone_out, .warning_tone_out, .wideband_select, .mode_switch_erase, .mode_select,
    .vol_switch, .fixed_level_audio_req, .received_signal, .slicer_in, .squelch_override,
    .tone_squelch_in, .mode_decoded, .zeroise_line_out, .whisper_out, .cipher_variant_select,
    .cipher_variant_select_hi, .secure_select_n, .crypto_tx_control, .crypto_clockgen_power,
    .tfilter_power, .fill_clock, .transmit_control_n, .synth_clock, .synth_ref_out,
    .synth_var_out, .synth_frame_out, .init_data_oe, .squelch_path, .mod_gain_sel_a,
    .mod_gain_sel_b, .audio_filter_power_n, .rx_audio_pass, .tone_level_pin, .tone_path_high,
    .tone_path_low, .vol_code, .vol_mux_sel, .amp_from_wideband, .audio_amp_power,
    .clear_to_send_n, .tx_lamp_n, .ptt_pull_low, .tsq_filter_power, .eeprom_power);

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one strobe pulse, returns when the bank shows the data
  task automatic latch(input bit sel_b, input logic [7:0] d);
    port_b_data = d;
    if (sel_b) latch_strobe_b = 1'b1;
    else latch_strobe_a = 1'b1;
    step(1);
    latch_strobe_a = 1'b0;
    latch_strobe_b = 1'b0;
  endtask

  task automatic t_reset_values();
    chk("bank_a", rcbio_pkg::BANK_A_RST, bank_a_v);
    chk("bank_b", 8'h0a, bank_b_v);
    chk("zeroise", 8'h01, zeroise_line_out);
    chk("rx_pass", 8'h00, rx_audio_pass);
  endtask

  task automatic t_latches();
    port_b_data = 8'h8e;
    latch_strobe_a = 1'b1;
    step(1);
    chk("bank_a early", 8'h8a, bank_a_v & 8'hfb);
    step(1);
    chk("bank_a", 8'h8e, bank_a_v);
    chk("rx_pass", 8'h01, rx_audio_pass);
    // strobe stays high: new data must not be taken
    port_b_data = 8'h71;
    step(3);
    chk("bank_a held", 8'h8e, bank_a_v);
    latch_strobe_a = 1'b0;
    step(1);
    latch(1'b1, 8'hac);
    chk("bank_b", 8'hae, bank_b_v);
    chk("bank_a kept", 8'h8e, bank_a_v);
    step(1);
    latch(1'b1, 8'h00);
    chk("bank_b off", 8'h02, bank_b_v);
    chk("gain", 8'h01, {mod_gain_sel_b, mod_gain_sel_a});
  endtask

  task automatic t_variant();
    latch(1'b0, 8'h04);
    step(1);
    chk("variant", 8'h01, cipher_variant_select);
    fill_frame = 1'b1;
    step(2);
    chk("variant fill", 8'h00, cipher_variant_select);
    fill_frame = 1'b0;
    step(2);
    chk("variant after", 8'h01, cipher_variant_select);
    latch(1'b0, 8'h00);
    step(1);
    chk("variant a", 8'h00, cipher_variant_select);
  endtask

  task automatic t_zeroise();
    for (int i = 0; i < 4; i++) begin
      req_erase_n = i[0];
      zeroise_command = i[1];
      step(2);
      chk("zeroise", {7'h00, i[0] & ~i[1]}, zeroise_line_out);
    end
  endtask

  task automatic t_volume();
    for (int c = 0; c < 8; c++) begin
      req_vol = 3'(c);
      step(2);
      chk("vol_code", 8'(c), vol_code);
      chk("mux", 8'h01 << c, vol_mux_sel);
      chk("whisper", {7'h00, c < 2}, whisper_out);
      chk("override", {7'h00, c > 5}, squelch_override);
    end
    req_vol = 3'h1;
    req_fla = 1'b1;
    step(2);
    chk("vol fixed", rcbio_pkg::VOL_FIXED, vol_code);
    chk("mux fixed", 8'h10, vol_mux_sel);
    req_fla = 1'b0;
  endtask

  task automatic t_mode();
    logic [1:0] tbl [4];
    tbl = '{rcbio_pkg::MODE_SEC_B, rcbio_pkg::MODE_CLEAR, rcbio_pkg::MODE_SEC_A,
            rcbio_pkg::MODE_ZEROISE};
    for (int m = 0; m < 4; m++) begin
      req_mode = 2'(m);
      step(2);
      chk("mode", tbl[m], mode_decoded);
    end
  endtask

  task automatic t_squelch();
    latch(1'b0, 8'h71);
    req_rx = 1'b1;
    step(2);
    chk("sq rx", 8'h01, squelch_path);
    latch(1'b0, 8'h51);
    step(2);
    chk("sq tone lo", 8'h00, squelch_path);
    squelch_tone_out = 1'b1;
    req_rx = 1'b0;
    step(2);
    chk("sq tone hi", 8'h01, squelch_path);
    req_slicer = 1'b1;
    irq_gate_enable = 1'b1;
    step(2);
    chk("tsq on", 8'h01, tone_squelch_in);
    irq_gate_enable = 1'b0;
    step(1);
    chk("tsq gated", 8'h00, tone_squelch_in);
    irq_gate_enable = 1'b1;
    reset_n = 1'b0;
    step(1);
    chk("tsq reset", 8'h00, tone_squelch_in);
    chk("bank_a reset", rcbio_pkg::BANK_A_RST, bank_a_v);
    reset_n = 1'b1;
    step(1);
  endtask

  task automatic t_pass();
    logic b;
    warning_tone_out = 1'b1;
    for (int i = 0; i < 2; i++) begin
      b = i[0];
      serial_clock = b;
      synth_ref_divisor_data = b;
      synth_var_divisor_data = ~b;
      synth_frame = b;
      tone_level_select = b;
      wideband_select = b;
      pwm_reply_out = b;
      step(2);
      chk("sclk", {4'h0, b, b, ~b, b},
          {synth_clock, fill_clock, synth_var_out, synth_frame_out});
      chk("ref", {6'h00, b, b}, {synth_ref_out, init_data_oe});
      chk("tone", {5'h00, b, b, ~b}, {tone_level_pin, tone_path_high, tone_path_low});
      chk("wide", {7'h00, b}, amp_from_wideband);
      chk("ptt", {7'h00, b}, ptt_pull_low);
      chk("clkgen", 8'h01, crypto_clockgen_power);
    end
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    summarize();
  end

  initial begin
    step(5);
    t_reset_values();
    reset_n = 1'b1;
    step(1);
    t_latches();
    t_variant();
    t_zeroise();
    t_volume();
    t_mode();
    t_squelch();
    t_pass();
    summarize();
  end
endmodule // test_radio_control_board_io_logic
